/* rtl/elm_pkg.sv */
// Purpose: shared constants and types of the event log mission control block
// Assumes: byte-wide register port, 50 MHz core clock
// Notes:   control byte layout matches elm_ctrl_type field order, msb first
package elm_pkg;

  // register offsets on the byte register port
  localparam logic [7:0] CTRL_OFFSET   = 8'h0E;
  localparam logic [7:0] STATUS_OFFSET = 8'h0F;

  // control register field positions
  localparam int CTRL_ARM_BIT      = 7;
  localparam int CTRL_ERASE_BIT    = 6;
  localparam int CTRL_WRAP_BIT     = 3;
  localparam int CTRL_OSC_BIT      = 0;

  // status register field positions (other bits of that byte live elsewhere)
  localparam int STAT_WIPED_BIT    = 6;
  localparam int STAT_ACTIVE_BIT   = 5;
  localparam int STAT_WIPE_CMD_BIT = 4;
  localparam int STAT_WRAP_BIT     = 2;

  // values after reset
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic       WIPED_RESET = 1'b0;

  // interval_select and edge_select encodings
  localparam logic [1:0] INTERVAL_ALARM = 2'h0;
  localparam logic [1:0] INTERVAL_SEC   = 2'h1;
  localparam logic [1:0] INTERVAL_MIN   = 2'h2;
  localparam logic [1:0] INTERVAL_HOUR  = 2'h3;
  localparam logic [1:0] EDGE_NONE      = 2'h0;
  localparam logic [1:0] EDGE_FALL      = 2'h1;
  localparam logic [1:0] EDGE_RISE      = 2'h2;
  localparam logic [1:0] EDGE_BOTH      = 2'h3;

  // gap counter limit and log geometry
  localparam logic [15:0] GAP_MAX     = 16'hFFFF;
  localparam int          LOG_WORDS   = 1024;
  localparam int          EVT_CNT_W   = 24;
  localparam int          STAMP_W     = 64;

  typedef struct packed {
    logic       arm;
    logic       erase_arm;
    logic [1:0] interval;
    logic       wrap_en;
    logic [1:0] edge_sel;
    logic       osc_en;
  } elm_ctrl_type;

  typedef enum logic [1:0] {
    ELM_IDLE  = 2'b01,
    ELM_ERASE = 2'b10
  } elm_state_type;

endpackage

/* rtl/elm_edge_detect.sv */
// Purpose: synchronise the event pin and pick the configured edges
// Assumes: event_pin is asynchronous to core_clk
// Notes:   one-cycle event pulse, two to three cycles after the pin moves
`timescale 1ns/1ns
`default_nettype none
module elm_edge_detect (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       event_pin,
  input  wire logic [1:0] edge_select,
  output logic            event_pulse
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic event_nxt;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= event_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // edge pick; the all-zero select never fires
  wire rise_w = sync2_r & ~prev_r;
  wire fall_w = ~sync2_r & prev_r;
  assign event_nxt = (edge_select[1] & rise_w) | (edge_select[0] & fall_w);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= event_nxt;
    end
  end

endmodule
`default_nettype wire

/* rtl/elm_mission_ctrl.sv */
// Purpose: mission control of the event recorder: arm, start, stop, erase, log
// Assumes: tick inputs are one-cycle pulses from the clock/calendar on core_clk
// Notes:   rules below, carried by the logic blocks further down
// Notes on behaviour
// - arm settable only while memory reads wiped
// - armed pin event starts mission and stamps
// - host start while unarmed also sets arm
// - any mission stop clears arm
// - erase needs erase_arm then wipe_command
// - erase end clears erase_arm, sets wiped
// - other command after erase_arm cancels it
// - interval_select picks alarm, second, minute, hour
// - no mission start with interval zero
// - gap saturation logs maximum and restarts
// - saturation leaves event counter alone
// - later events log gap and restart it
// - gap follows clock register increments
// - event before first tick logs zero
// - wrap restamps, then overwrites from zero
// - no wrap: stop logging, keep counting
// - edge_select picks falling, rising, both
// - zero edge_select ignores pin, no start
// - osc_enable clear halts timekeeping
// - no start or erase without osc_enable
// - main supply keeps oscillator running
// - any host write during mission stops it
// - host writing mission_active zero stops mission
// - event after full log sets wrap_flag
// - mission start clears wiped_flag
`timescale 1ns/1ns
`default_nettype none
module elm_mission_ctrl #(
  parameter int LOG_WORDS = elm_pkg::LOG_WORDS,
  parameter int CNT_W     = elm_pkg::EVT_CNT_W,
  parameter int STAMP_W   = elm_pkg::STAMP_W,
  localparam int AW       = $clog2(LOG_WORDS)
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               wr_en,
  input  wire logic [7:0]         wr_addr,
  input  wire logic [7:0]         wr_data,
  input  wire logic [7:0]         rd_addr,
  output logic      [7:0]         rd_data,
  input  wire logic               event_pin,
  input  wire logic               supply_main_high,
  input  wire logic               sec_tick,
  input  wire logic               min_tick,
  input  wire logic               hour_tick,
  input  wire logic [STAMP_W-1:0] rtc_time,
  output logic                    osc_run,
  output logic                    alarm_int_en,
  output logic                    log_we,
  output logic      [AW-1:0]      log_addr,
  output logic      [15:0]        log_data,
  output logic      [STAMP_W-1:0] start_stamp,
  output logic      [15:0]        wrap_stamp,
  output logic      [CNT_W-1:0]   event_count,
  output logic                    mission_active,
  output logic                    wiped_flag,
  output logic                    wrap_flag
);

  if (LOG_WORDS < 2 || (1 << AW) != LOG_WORDS) begin : g_bad_depth
    $error("LOG_WORDS must be a power of two of at least 2");
  end
  if (CNT_W < 2) begin : g_bad_cnt
    $error("CNT_W must be at least 2");
  end

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
    reg_hit = (addr == offs);
  endfunction

  elm_pkg::elm_ctrl_type  ctrl_r;
  elm_pkg::elm_state_type state_r;
  logic [15:0]            gap_r;
  logic [AW-1:0]          ptr_r;
  logic [AW-1:0]          erase_idx_r;
  logic                   full_r;
  logic                   supply_s1_r;
  logic                   supply_s2_r;
  logic                   event_pulse;

  elm_edge_detect u_edge (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .event_pin   (event_pin),
    .edge_select (ctrl_r.edge_sel),
    .event_pulse (event_pulse)
  );

  // supply comparator output arrives from the analog side, so synchronise it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_s1_r <= 1'b0;
      supply_s2_r <= 1'b0;
    end else begin
      supply_s1_r <= supply_main_high;
      supply_s2_r <= supply_s1_r;
    end
  end

  // command decode
  wire ctrl_wr  = wr_en & reg_hit(wr_addr, elm_pkg::CTRL_OFFSET);
  wire stat_wr  = wr_en & reg_hit(wr_addr, elm_pkg::STATUS_OFFSET);
  wire idle_w   = (state_r == elm_pkg::ELM_IDLE);
  wire start_ok = ctrl_r.osc_en & (ctrl_r.interval != elm_pkg::INTERVAL_ALARM)
                & (ctrl_r.edge_sel != elm_pkg::EDGE_NONE) & wiped_flag & idle_w;
  wire host_start = stat_wr & wr_data[elm_pkg::STAT_ACTIVE_BIT] & ~ctrl_r.arm
                  & ~mission_active & start_ok;
  wire pin_start  = event_pulse & ctrl_r.arm & ~mission_active & start_ok;
  wire any_start  = host_start | pin_start;
  wire mission_end = mission_active & wr_en;
  wire wipe_go    = stat_wr & wr_data[elm_pkg::STAT_WIPE_CMD_BIT] & ctrl_r.erase_arm
                  & ctrl_r.osc_en & idle_w;
  wire erase_done = (state_r == elm_pkg::ELM_ERASE) & (erase_idx_r == AW'(LOG_WORDS - 1));

  // tick for the gap counter follows the chosen calendar register
  wire tick_pick  = (ctrl_r.interval == elm_pkg::INTERVAL_SEC)  ? sec_tick :
                    (ctrl_r.interval == elm_pkg::INTERVAL_MIN)  ? min_tick :
                    (ctrl_r.interval == elm_pkg::INTERVAL_HOUR) ? hour_tick : 1'b0;
  wire tick_w     = tick_pick & osc_run;
  wire evt_live   = mission_active & event_pulse & ~mission_end;
  wire sat_w      = mission_active & ~mission_end & ~event_pulse & tick_w
                  & (gap_r == elm_pkg::GAP_MAX - 16'h0001);
  wire ptr_last   = (ptr_r == AW'(LOG_WORDS - 1));
  wire log_room   = ~full_r;

  // control byte: arm gated by wiped, erase_arm dropped by any other command
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= elm_pkg::CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_r     <= elm_pkg::elm_ctrl_type'(wr_data);
        ctrl_r.arm <= wr_data[elm_pkg::CTRL_ARM_BIT] & wiped_flag & ~mission_active;
      end else if (wr_en & ~wipe_go) begin
        ctrl_r.erase_arm <= 1'b0;
      end
      if (host_start) begin
        ctrl_r.arm <= 1'b1;
      end
      if (mission_end) begin
        ctrl_r.arm <= 1'b0;
      end
      if (erase_done) begin
        ctrl_r.erase_arm <= 1'b0;
      end
    end
  end

  // erase sequencer walks every log word writing zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= elm_pkg::ELM_IDLE;
      erase_idx_r <= '0;
    end else begin
      case (state_r)
        elm_pkg::ELM_IDLE: begin
          erase_idx_r <= '0;
          if (wipe_go) begin
            state_r <= elm_pkg::ELM_ERASE;
          end
        end
        elm_pkg::ELM_ERASE: begin
          erase_idx_r <= erase_idx_r + AW'(1);
          if (erase_done) begin
            state_r <= elm_pkg::ELM_IDLE;
          end
        end
        default: begin
          state_r <= elm_pkg::ELM_IDLE;
        end
      endcase
    end
  end

  // mission state, counters and stamps
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mission_active <= 1'b0;
      wiped_flag     <= elm_pkg::WIPED_RESET;
      wrap_flag      <= 1'b0;
      full_r         <= 1'b0;
      ptr_r          <= '0;
      gap_r          <= '0;
      event_count    <= '0;
      start_stamp    <= '0;
      wrap_stamp     <= '0;
    end else if (erase_done) begin
      wiped_flag  <= 1'b1;
      wrap_flag   <= 1'b0;
      full_r      <= 1'b0;
      ptr_r       <= '0;
      gap_r       <= '0;
      event_count <= '0;
      start_stamp <= '0;
      wrap_stamp  <= '0;
    end else if (any_start) begin
      mission_active <= 1'b1;
      wiped_flag     <= 1'b0;
      start_stamp    <= rtc_time;
      wrap_stamp     <= '0;
      event_count    <= event_count + CNT_W'(1);
      gap_r          <= '0;
      ptr_r          <= '0;
      full_r         <= 1'b0;
    end else begin
      if (mission_end) begin
        mission_active <= 1'b0;
      end
      if (evt_live) begin
        event_count <= event_count + CNT_W'(1);
        gap_r       <= '0;
        if (log_room) begin
          ptr_r  <= ptr_r + AW'(1);
          full_r <= ptr_last;
        end else begin
          wrap_flag <= 1'b1;
          if (ctrl_r.wrap_en) begin
            start_stamp <= rtc_time;
            wrap_stamp  <= gap_r;
            full_r      <= 1'b0;
          end
        end
      end else if (sat_w) begin
        gap_r <= '0;
        if (log_room) begin
          ptr_r  <= ptr_r + AW'(1);
          full_r <= ptr_last;
        end
      end else if (mission_active & tick_w) begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end

  // log write port: erase zeros, event gaps or the saturation marker
  wire            log_we_nxt   = (state_r == elm_pkg::ELM_ERASE) | ((evt_live | sat_w) & log_room);
  wire [AW-1:0]   log_addr_nxt = (state_r == elm_pkg::ELM_ERASE) ? erase_idx_r : ptr_r;
  wire [15:0]     log_data_nxt = (state_r == elm_pkg::ELM_ERASE) ? 16'h0000 :
                                 sat_w ? elm_pkg::GAP_MAX : gap_r;
  wire [7:0]      stat_byte    = {1'b0, wiped_flag, mission_active, 1'b0, 1'b0, wrap_flag,
                                  2'h0};
  wire [7:0]      rd_nxt       = reg_hit(rd_addr, elm_pkg::CTRL_OFFSET)   ? 8'(ctrl_r) :
                                 reg_hit(rd_addr, elm_pkg::STATUS_OFFSET) ? stat_byte : 8'h00;

  // registered outputs; the supply override trumps osc_enable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      log_we       <= 1'b0;
      log_addr     <= '0;
      log_data     <= 16'h0000;
      rd_data      <= 8'h00;
      osc_run      <= 1'b0;
      alarm_int_en <= 1'b0;
    end else begin
      log_we       <= log_we_nxt;
      log_addr     <= log_addr_nxt;
      log_data     <= log_data_nxt;
      rd_data      <= rd_nxt;
      osc_run      <= ctrl_r.osc_en | supply_s2_r;
      alarm_int_en <= (ctrl_r.interval == elm_pkg::INTERVAL_ALARM);
    end
  end

  // checks tying outputs back to their causes
  AST_ARM_NEEDS_WIPED: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(ctrl_r.arm) |-> $past(wiped_flag))
    else $error("arm rose while memory not wiped");

  AST_STOP_CLEARS_ARM: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(mission_active) |-> !ctrl_r.arm)
    else $error("arm left set after mission stop");

  AST_START_NEEDS_INTERVAL: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mission_active) |-> $past(ctrl_r.interval) != elm_pkg::INTERVAL_ALARM)
    else $error("mission started with interval zero");

  AST_START_NEEDS_OSC: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mission_active) |-> $past(ctrl_r.osc_en) && $past(ctrl_r.edge_sel) != 2'h0)
    else $error("mission started without oscillator or edge");

  AST_START_CLEARS_WIPED: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mission_active) |-> !wiped_flag && event_count == $past(event_count) + CNT_W'(1))
    else $error("start did not clear wiped or count the event");

  AST_ERASE_DONE: assert property (@(posedge core_clk) disable iff (!arst_n)
    erase_done |=> wiped_flag && !ctrl_r.erase_arm && event_count == '0 && !wrap_flag)
    else $error("erase end state wrong");

  AST_SAT_NO_COUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
    sat_w |=> gap_r == 16'h0000 && $stable(event_count))
    else $error("saturation changed event count");

  AST_WRITE_STOPS: assert property (@(posedge core_clk) disable iff (!arst_n)
    mission_active && wr_en |=> !mission_active)
    else $error("host write did not stop mission");

  AST_OSC_FOLLOWS: assert property (@(posedge core_clk) disable iff (!arst_n)
    supply_s2_r |=> osc_run)
    else $error("oscillator stopped while on main supply");

  AST_NO_EDGE_NO_EVENT: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctrl_r.edge_sel == elm_pkg::EDGE_NONE ##1 ctrl_r.edge_sel == elm_pkg::EDGE_NONE
    |-> !event_pulse)
    else $error("event seen with edge select zero");

endmodule
`default_nettype wire

/* sim/elm_host_model.sv */
// Purpose: far side of the control block: register writer and event source
// Assumes: one write command per wr_en pulse, ticks stand for calendar increments
// Notes:   a released write bus shows the inverse of the last value, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module elm_host_model (
  input  wire logic       core_clk,
  output var  logic       wr_en,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data,
  output var  logic       event_pin,
  output var  logic       sec_tick,
  output var  logic       min_tick
);
  // quiet bus and pin at time zero
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    event_pin = 1'b0;
    sec_tick = 1'b0;
    min_tick = 1'b0;
  end

  // one strobe per command; erase pairs and start/stop come from the caller in order
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge core_clk);
    #2;
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask

  // one level change of the event line
  task automatic tog;
    @(posedge core_clk);
    #2;
    event_pin = ~event_pin;
  endtask

  // n calendar second increments; minute ticks run along, so the minute interval counts the same n
  task automatic tick(input int n);
    @(posedge core_clk);
    #2;
    sec_tick = 1'b1;
    min_tick = 1'b1;
    repeat (n) @(posedge core_clk);
    #2;
    sec_tick = 1'b0;
    min_tick = 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/event_log_mission_control_bench.sv */
// Purpose: self-checking bench for the mission control block
// Assumes: host writes and event pin come from the far side model
// Notes:   a queue model predicts every log memory write in order
`timescale 1ns/1ns
`default_nettype none
module event_log_mission_control_bench;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  rd_addr = 8'h00;
  logic        supply_main_high = 1'b0;
  logic [63:0] rtc_time = 64'h0;
  wire         wr_en, event_pin, sec_tick, min_tick;
  wire  [7:0]  wr_addr, wr_data;
  logic [7:0]  rd_data;
  logic        osc_run, alarm_int_en, log_we, mission_active, wiped_flag, wrap_flag;
  logic [9:0]  log_addr;
  logic [15:0] log_data, wrap_stamp;
  logic [63:0] start_stamp, stamp;
  logic [23:0] event_count;
  logic [7:0]  ctrl;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  int          ptr, gap, cnt, mode, wgap, n;
  bit          active, armed, full, wrapen, wflag;
  logic [25:0] expq[$];

  always #10 core_clk = ~core_clk;

  elm_host_model far (.core_clk(core_clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .event_pin(event_pin), .sec_tick(sec_tick), .min_tick(min_tick));

  elm_mission_ctrl dut (.core_clk(core_clk), .arst_n(arst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .event_pin(event_pin), .supply_main_high(supply_main_high), .sec_tick(sec_tick),
    .min_tick(min_tick), .hour_tick(1'b0), .rtc_time(rtc_time), .osc_run(osc_run),
    .alarm_int_en(alarm_int_en), .log_we(log_we), .log_addr(log_addr),
    .log_data(log_data), .start_stamp(start_stamp), .wrap_stamp(wrap_stamp),
    .event_count(event_count), .mission_active(mission_active),
    .wiped_flag(wiped_flag), .wrap_flag(wrap_flag));

  task automatic end_of_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_log(input logic [25:0] g);
    logic [25:0] e;
    e = (expq.size() == 0) ? ~g : expq.pop_front();
    chk_val("log write", e, g);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    #2;
    rd_addr = a;
    @(posedge core_clk);
    #2;
    chk_val($sformatf("reg %h", a), e, rd_data);
  endtask

  // cycle ceiling cuts a hang short; every log write is compared at its edge
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 96000) begin
      error_cnt++;
      end_of_test();
    end else if (log_we === 1'b1)
      chk_log({log_addr, log_data});
  end

  // one pin change plus what the model expects it to do
  task automatic tog;
    bit hit;
    far.tog();
    rtc_time = {$urandom, $urandom};
    hit = mode == 3 || (mode == 2 && event_pin) || (mode == 1 && !event_pin);
    if (hit && active) begin
      if (full && wrapen) begin
        ptr = 0;
        full = 0;
        wflag = 1;
        wgap = gap;
        stamp = rtc_time;
      end else if (full)
        wflag = 1;
      else begin
        expq.push_back({10'(ptr), 16'(gap)});
        ptr++;
        full = ptr == 1024;
      end
      gap = 0;
      cnt++;
    end else if (hit && armed) begin
      active = 1;
      gap = 0;
      cnt++;
      stamp = rtc_time;
    end
    repeat (6) @(posedge core_clk);
    #2;
  endtask

  // elapsed count advances per tick; the maximum is logged and restarts the count
  task automatic tick(input int k);
    far.tick(k);
    if (active) begin
      for (int i = 0; i < k; i++) begin
        gap++;
        if (gap == 65535) begin
          if (!full) expq.push_back({10'(ptr), 16'hFFFF});
          if (!full) ptr++;
          gap = 0;
        end
      end
    end
    repeat (2) @(posedge core_clk);
    #2;
  endtask

  task automatic erase;
    far.wr(8'h0E, 8'h41);
    far.wr(8'h0F, 8'h10);
    for (int i = 0; i < 1024; i++) expq.push_back({10'(i), 16'h0000});
    repeat (1030) @(posedge core_clk);
    #2;
    chk_val("wiped", 1, wiped_flag);
    chk_val("count", 0, event_count);
    chk_val("osc", 1, osc_run);
    chk_val("wrap flag", 0, wrap_flag);
    chk_reg(8'h0E, 8'h01);
    cnt = 0;
    ptr = 0;
    full = 0;
    wflag = 0;
  endtask

  initial begin
    void'($urandom(82013));
    repeat (3) @(posedge core_clk);
    #2;
    arst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    chk_reg(8'h0E, 8'h00);
    chk_reg(8'h0F, 8'h00);
    chk_val("alarm enable", 1, alarm_int_en);
    chk_val("osc", 0, osc_run);
    supply_main_high = 1'b1;
    repeat (6) @(posedge core_clk);
    #2;
    chk_val("osc", 1, osc_run);
    supply_main_high = 1'b0;
    far.wr(8'h0E, 8'h80);
    chk_reg(8'h0E, 8'h00);
    far.wr(8'h0E, 8'h40);
    far.wr(8'h0F, 8'h10);
    repeat (20) @(posedge core_clk);
    chk_val("wiped", 0, wiped_flag);
    far.wr(8'h0E, 8'h41);
    far.wr(8'h0F, 8'h00);
    chk_reg(8'h0E, 8'h01);
    erase();
    far.wr(8'h0E, 8'h05);
    far.wr(8'h0F, 8'h20);
    chk_val("active", 0, mission_active);
    far.wr(8'h0E, 8'h91);
    armed = 1;
    mode = 0;
    repeat (2) tog();
    chk_val("active", 0, mission_active);
    chk_val("alarm enable", 0, alarm_int_en);
    far.wr(8'h0E, 8'h93);
    mode = 1;
    repeat (2) tog();
    chk_val("active", 1, mission_active);
    chk_val("start stamp", stamp, start_stamp);
    chk_val("wrap stamp", 0, wrap_stamp);
    chk_val("wiped", 0, wiped_flag);
    repeat (2) tog();
    n = 1 + $urandom % 7;
    tick(n);
    repeat (2) tog();
    tick(65535);
    tick(2);
    repeat (2) tog();
    chk_val("count", cnt, event_count);
    far.wr(8'h10, 8'h00);
    active = 0;
    armed = 0;
    repeat (2) tog();
    chk_val("active", 0, mission_active);
    chk_reg(8'h0E, 8'h13);
    for (int w = 0; w < 2; w++) begin
      erase();
      wrapen = w;
      mode = w ? 2 : 3;
      ctrl = w ? 8'h2D : 8'h17;
      far.wr(8'h0E, ctrl);
      rtc_time = {$urandom, $urandom};
      far.wr(8'h0F, 8'h20);
      active = 1;
      armed = 1;
      cnt = 1;
      gap = 0;
      chk_val("start stamp", rtc_time, start_stamp);
      chk_reg(8'h0E, ctrl | 8'h80);
      // once full, let the gap grow so the wrap stamp carries a real value
      while (!wflag) begin
        if (full) tick(1 + $urandom % 5);
        tog();
      end
      chk_val("wrap flag", 1, wrap_flag);
      if (w) chk_val("start stamp", stamp, start_stamp);
      if (w) chk_val("wrap stamp", wgap, wrap_stamp);
      repeat (2) tog();
      chk_val("count", cnt, event_count);
      far.wr(8'h0F, 8'h00);
      active = 0;
      armed = 0;
      chk_reg(8'h0E, ctrl);
      chk_val("active", 0, mission_active);
      chk_val("pending", 0, expq.size());
    end
    end_of_test();
  end
endmodule
`default_nettype wire
